// ---- hw/lcfc_cluster.sv ----
// Cluster of twelve logic cells with LUT, carry chain, storage and APB setup.
//
// Notes on behaviour
// - Each four-input table realises any Boolean function set by its mask.
// - Sum output is table result XOR the incoming carry.
// - Sum stays available beside the plain table output in logic use.
// - Each group of three cells shares a three-bit look-ahead carry slice toward the next group.
// - Carry chain is hardwired through all twelve cells of the cluster.
// - Storage element acts as edge register or level latch by configuration.
// - Async load forces configured one or zero regardless of cell clock.
// - Sync load forces configured one or zero at next active clock edge.
// - Clock enable gates whether an active edge updates storage.
// - Storage data comes from direct input or the table output.
// - Storage usable with the table or alone, table serving other logic.
`timescale 1ns/1ps
module lcfc_cluster
	import lcfc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Fabric side
	input wire logic cell_clk,
	input wire logic carry_in,
	input wire lcfc_cell_in_type [LCFC_CELLS-1:0] cell_in,
	output lcfc_cell_out_type [LCFC_CELLS-1:0] cell_out,
	output logic carry_out
);

	// ==========================================================
	// Helpers

	// Carries out of three chained cells from propagate and generate.
	function automatic logic [2:0] lookahead3(input logic [2:0] p,
		input logic [2:0] g, input logic cin);
		logic [2:0] c;
		c[0] = g[0] | (p[0] & cin);
		c[1] = g[1] | (p[1] & g[0]) | (p[1] & p[0] & cin);
		c[2] = g[2] | (p[2] & g[1]) | (p[2] & p[1] & g[0])
			| (p[2] & p[1] & p[0] & cin);
		return c;
	endfunction

	// Register index of a configuration address, or -1 when unmapped.
	function automatic int cfg_index(input logic [7:0] addr);
		int idx;
		idx = -1;
		if (addr[1:0] == 2'b00 && addr >= LCFC_CFG_BASE
			&& addr <= LCFC_CFG_LAST)
		begin
			idx = int'(addr[7:2]);
		end
		return idx;
	endfunction

	// ==========================================================
	// Configuration and storage state
	lcfc_cfg_type [LCFC_CELLS-1:0] cfg_q;
	logic [LCFC_CELLS-1:0] store_q;
	logic cell_clk_prev_q;
	logic cell_rise;

	// Combinational cell values.
	logic [LCFC_CELLS-1:0] lut_y;
	logic [LCFC_CELLS-1:0] cin_cell;
	logic [LCFC_CELLS-1:0] cout_cell;
	logic [LCFC_CELLS-1:0] sum_y;
	logic [LCFC_CELLS-1:0] data_pick;

	// APB decode terms.
	logic apb_setup;
	logic apb_write;
	int wr_idx;
	int rd_idx;

	assign apb_setup = psel & ~penable;
	assign apb_write = psel & penable & pready & pwrite;
	assign wr_idx = cfg_index(paddr);
	assign rd_idx = cfg_index(paddr);

	// ==========================================================
	// Lookup tables and carry chain
	always_comb
	begin
		logic [2:0] p3;
		logic [2:0] g3;
		logic [2:0] c3;
		logic [2:0] cin3;
		logic cgrp;
		p3 = 3'b000;
		g3 = 3'b000;
		c3 = 3'b000;
		cin3 = 3'b000;
		cgrp = carry_in;
		for (int i = 0; i < LCFC_CELLS; i++)
		begin
			lut_y[i] = cfg_q[i].lut_mask[cell_in[i].lut_in];
		end
		for (int k = 0; k < LCFC_GROUPS; k++)
		begin
			for (int j = 0; j < LCFC_GROUP; j++)
			begin
				p3[j] = lut_y[k*LCFC_GROUP+j];
				g3[j] = cell_in[k*LCFC_GROUP+j].lut_in[0];
			end
			c3 = lookahead3(p3, g3, cgrp);
			// Carry into each cell: the group input, then the lower carries.
			cin3 = {c3[1:0], cgrp};
			for (int j = 0; j < LCFC_GROUP; j++)
			begin
				cin_cell[k*LCFC_GROUP+j] = cin3[j];
				cout_cell[k*LCFC_GROUP+j] = c3[j];
			end
			cgrp = c3[LCFC_GROUP-1];
		end
		for (int i = 0; i < LCFC_CELLS; i++)
		begin
			sum_y[i] = lut_y[i] ^ cin_cell[i];
			data_pick[i] = cfg_q[i].data_sel ? cell_in[i].direct_input
				: lut_y[i];
		end
	end

	// ==========================================================
	// Storage elements
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cell_clk_prev_q <= 1'b0;
		end
		else
		begin
			cell_clk_prev_q <= cell_clk;
		end
	end

	// Register mode acts on the first edge that sees cell_clk high.
	assign cell_rise = cell_clk & ~cell_clk_prev_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			store_q <= {LCFC_CELLS{LCFC_STORE_RST}};
		end
		else
		begin
			for (int i = 0; i < LCFC_CELLS; i++)
			begin
				if (cell_in[i].async_load)
				begin
					store_q[i] <= cfg_q[i].async_load_value;
				end
				else if (cfg_q[i].latch_mode ? cell_clk
					: cell_rise)
				begin
					if (cell_in[i].clk_en)
					begin
						store_q[i] <= cell_in[i].sync_load
							? cfg_q[i].sync_load_value : data_pick[i];
					end
				end
			end
		end
	end

	// ==========================================================
	// Registered fabric outputs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cell_out <= '0;
		end
		else
		begin
			for (int i = 0; i < LCFC_CELLS; i++)
			begin
				cell_out[i].table_out <= lut_y[i];
				cell_out[i].sum_out <= sum_y[i];
				cell_out[i].stored_out <= store_q[i];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			carry_out <= 1'b0;
		end
		else
		begin
			carry_out <= cout_cell[LCFC_CELLS-1];
		end
	end

	// ==========================================================
	// Configuration writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			for (int i = 0; i < LCFC_CELLS; i++)
			begin
				cfg_q[i] <= '0;
				cfg_q[i].lut_mask <= LCFC_MASK_RST;
			end
		end
		else if (apb_write && wr_idx >= 0)
		begin
			if (pstrb[0])
			begin
				cfg_q[wr_idx].lut_mask[7:0] <= pwdata[7:0];
			end
			if (pstrb[1])
			begin
				cfg_q[wr_idx].lut_mask[15:8] <= pwdata[15:8];
			end
			if (pstrb[2])
			begin
				cfg_q[wr_idx].latch_mode <= pwdata[LCFC_LATCH_BIT];
				cfg_q[wr_idx].async_load_value <= pwdata[LCFC_ASYNC_VAL_BIT];
				cfg_q[wr_idx].sync_load_value <= pwdata[LCFC_SYNC_VAL_BIT];
				cfg_q[wr_idx].data_sel <= pwdata[LCFC_DSEL_BIT];
			end
		end
	end

	// ==========================================================
	// APB answer, prepared in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else if (apb_setup)
		begin
			pready <= 1'b1;
			pslverr <= (rd_idx < 0) && (paddr != LCFC_STORED_ADDR)
				&& (paddr != LCFC_OUTS_ADDR);
		end
		else
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Read data is taken in the setup cycle and held until the next one.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata <= '0;
		end
		else if (apb_setup)
		begin
			prdata <= '0;
			if (rd_idx >= 0)
			begin
				prdata[LCFC_CFG_BITS-1:0] <= cfg_q[rd_idx];
			end
			else if (paddr == LCFC_STORED_ADDR)
			begin
				prdata[LCFC_CELLS-1:0] <= store_q;
			end
			else if (paddr == LCFC_OUTS_ADDR)
			begin
				prdata[LCFC_CELLS-1:0] <= lut_y;
				prdata[LCFC_CARRY_BIT] <= cout_cell[LCFC_CELLS-1];
				prdata[LCFC_SUM_LSB+LCFC_CELLS-1:LCFC_SUM_LSB] <= sum_y;
			end
		end
	end

endmodule

// ---- hw/lcfc_pkg.sv ----
// Package with constants and types for the LUT, carry and flop cell cluster.
package lcfc_pkg;

	// ==========================================================
	// Cluster shape
	localparam int LCFC_CELLS = 12;
	localparam int LCFC_GROUP = 3;
	localparam int LCFC_GROUPS = LCFC_CELLS / LCFC_GROUP;
	localparam int LCFC_LUT_INPUTS = 4;
	localparam int LCFC_LUT_SIZE = 16;

	// ==========================================================
	// Register map, byte addresses on APB
	localparam logic [7:0] LCFC_CFG_BASE = 8'h00;
	localparam logic [7:0] LCFC_CFG_LAST = 8'h2c;
	localparam logic [7:0] LCFC_STORED_ADDR = 8'h30;
	localparam logic [7:0] LCFC_OUTS_ADDR = 8'h34;

	// ==========================================================
	// Field positions of a cell configuration word and of the outputs word
	localparam int LCFC_MASK_LSB = 0;
	localparam int LCFC_LATCH_BIT = 16;
	localparam int LCFC_ASYNC_VAL_BIT = 17;
	localparam int LCFC_SYNC_VAL_BIT = 18;
	localparam int LCFC_DSEL_BIT = 19;
	localparam int LCFC_CFG_BITS = 20;
	localparam int LCFC_CARRY_BIT = 12;
	localparam int LCFC_SUM_LSB = 16;

	// Values after reset.
	localparam logic [15:0] LCFC_MASK_RST = 16'h0000;
	localparam logic LCFC_STORE_RST = 1'b0;

	// ==========================================================
	// Types
	typedef struct packed
	{
		logic data_sel;
		logic sync_load_value;
		logic async_load_value;
		logic latch_mode;
		logic [15:0] lut_mask;
	} lcfc_cfg_type;

	typedef struct packed
	{
		logic [3:0] lut_in;
		logic direct_input;
		logic clk_en;
		logic async_load;
		logic sync_load;
	} lcfc_cell_in_type;

	typedef struct packed
	{
		logic table_out;
		logic sum_out;
		logic stored_out;
	} lcfc_cell_out_type;

endpackage

// ---- verification/lcfc_chk.sv ----
// Port assertions for the logic cell cluster.
`timescale 1ns/1ps
module lcfc_chk
	import lcfc_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	// Fabric
	input wire logic cell_clk,
	input wire logic carry_in,
	input wire lcfc_cell_in_type [LCFC_CELLS-1:0] cell_in,
	input wire lcfc_cell_out_type [LCFC_CELLS-1:0] cell_out
);
	logic [2:0] idle_q, off_q, frc_q;
	logic al0, st0;
	assign al0 = cell_in[0].async_load;
	assign st0 = cell_out[0].stored_out;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Counts quiet cycles of cell 0: no clock, no enable, forced.
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			idle_q <= 3'h0;
			off_q <= 3'h0;
			frc_q <= 3'h0;
		end
		else
		begin
			idle_q <= (cell_clk | al0) ? 3'h0 : idle_q + {2'h0, ~&idle_q};
			off_q <= (cell_in[0].clk_en | al0) ? 3'h0 : off_q + {2'h0, ~&off_q};
			frc_q <= (!al0 | pready) ? 3'h0 : frc_q + {2'h0, ~&frc_q};
		end
	property p_rst;
		disable iff (1'b0) !presetn |-> cell_out == '0 && !pready;
	endproperty
	a_rst: assert property (p_rst)
		else $error("outputs not clear in reset");
	property p_ready; psel && !penable |=> pready; endproperty
	a_ready: assert property (p_ready) else $error("no ready");
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("ready too long");
	property p_err;
		pready && paddr <= LCFC_OUTS_ADDR && paddr[1:0] == 2'h0 |-> !pslverr;
	endproperty
	a_err: assert property (p_err) else $error("error on mapped address");
	property p_sum;
		$past(presetn) |-> cell_out[0].sum_out ==
			(cell_out[0].table_out ^ $past(carry_in));
	endproperty
	a_sum: assert property (p_sum)
		else $error("sum is not table xor carry");
	property p_idle; idle_q >= 3'h5 |-> $stable(st0); endproperty
	a_idle: assert property (p_idle)
		else $error("store changed without clock");
	property p_off; off_q >= 3'h5 |-> $stable(st0); endproperty
	a_off: assert property (p_off)
		else $error("store changed while disabled");
	property p_frc; frc_q >= 3'h5 |-> $stable(st0); endproperty
	a_frc: assert property (p_frc)
		else $error("store moved under forced load");
	c_force: cover property (al0 [*3]);
	c_err: cover property (pready && pslverr);
	c_rise: cover property ($rose(st0));
endmodule
bind lcfc_cluster lcfc_chk u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
	.pslverr(pslverr), .cell_clk(cell_clk), .carry_in(carry_in),
	.cell_in(cell_in), .cell_out(cell_out));

// ---- verification/lcfc_fabric.sv ----
// Fabric model that drives the shared cell clock.
`timescale 1ns/1ps
module lcfc_fabric
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bench control
	input wire logic run,
	input wire logic level,
	// Toward the cluster
	output logic cell_clk
);
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			cell_clk <= 1'b0;
		else
			cell_clk <= run ? ~cell_clk : level;
endmodule

// ---- verification/tb_top.sv ----
// Self-checking bench for the logic cell cluster.
`timescale 1ns/1ps
module tb_top;
	import lcfc_pkg::*;
	typedef struct packed
	{
		logic [19:0] cfg;
		logic [3:0] li;
		logic [3:0] ctl;
		logic st;
	} lcfc_row_type;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic carry_in, carry_out, cell_clk, run, level;
	logic [7:0] paddr;
	logic [3:0] pstrb;
	logic [31:0] pwdata, prdata, rd;
	lcfc_cell_in_type [LCFC_CELLS-1:0] cell_in;
	lcfc_cell_out_type [LCFC_CELLS-1:0] cell_out;
	int failures, checks;
	// Config, table inputs, {direct, enable, async, sync}, stored value.
	lcfc_row_type rows [8] = '{'{20'h06996, 4'h7, 4'b0100, 1'b1},
		'{20'h08000, 4'he, 4'b0100, 1'b0}, '{20'h88000, 4'h0, 4'b1100, 1'b1},
		'{20'h88000, 4'h0, 4'b0000, 1'b1}, '{20'h88000, 4'h0, 4'b1101, 1'b0},
		'{20'ha8000, 4'h0, 4'b0010, 1'b1}, '{20'hc8000, 4'hf, 4'b1111, 1'b0},
		'{20'h18000, 4'hf, 4'b0100, 1'b1}};
	lcfc_cluster dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready, .pslverr, .cell_clk, .carry_in,
		.cell_in, .cell_out, .carry_out);
	lcfc_fabric fab (.pclk, .presetn, .run, .level, .cell_clk);
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end
	task automatic final_report();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1);
		// Zero wait states: the answer stands at the first access edge.
		check(n, 1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chain(input logic [15:0] m, input logic g, input logic c);
		logic cy, t;
		cy = c;
		t = m[{3'h0, g}];
		for (int i = 0; i < LCFC_CELLS; i++)
			apb(1'b1, 8'(4 * i), {16'h0, m});
		for (int i = 0; i < LCFC_CELLS; i++)
			cell_in[i] <= '{{3'h0, g}, 1'b0, 1'b0, 1'b0, 1'b0};
		carry_in <= c;
		repeat (4) @(posedge pclk);
		for (int i = 0; i < LCFC_CELLS - 1; i++)
			cy = g | (t & cy);
		check(cell_out[11].sum_out, t ^ cy);
		check(carry_out, g | (t & cy));
		apb(1'b0, LCFC_OUTS_ADDR, 32'h0);
		check(rd[12], g | (t & cy));
	endtask
	initial
	begin
		#150000;
		failures++;
		final_report();
	end
	initial
	begin
		{presetn, psel, penable, pwrite, run, level, carry_in} = '0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hf;
		cell_in = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, LCFC_CFG_BASE, 32'h0);
		check(rd, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		check(er, 1'b1);
		check(rd, 32'h0);
		foreach (rows[i])
		begin
			apb(1'b1, LCFC_CFG_BASE, {12'h0, rows[i].cfg});
			cell_in[0] <= {rows[i].li, rows[i].ctl};
			carry_in <= i[0];
			run <= 1'b1;
			repeat (8) @(posedge pclk);
			run <= 1'b0;
			repeat (6) @(posedge pclk);
			check(cell_out[0].table_out, rows[i].cfg[rows[i].li]);
			check(cell_out[0].sum_out, rows[i].cfg[rows[i].li] ^ i[0]);
			check(cell_out[0].stored_out, rows[i].st);
		end
		level <= 1'b1;
		apb(1'b1, LCFC_CFG_BASE, 32'h98000);
		cell_in[0] <= '{4'h0, 1'b0, 1'b1, 1'b0, 1'b0};
		repeat (6) @(posedge pclk);
		check(cell_out[0].stored_out, 1'b0);
		apb(1'b1, LCFC_CFG_BASE, 32'h88000);
		cell_in[0] <= '{4'h0, 1'b1, 1'b1, 1'b0, 1'b0};
		repeat (6) @(posedge pclk);
		check(cell_out[0].stored_out, 1'b0);
		level <= 1'b0;
		chain(16'hffff, 1'b0, 1'b1);
		chain(16'hffff, 1'b0, 1'b0);
		chain(16'h0000, 1'b1, 1'b0);
		chain(16'h0000, 1'b0, 1'b1);
		// Forced load with the cell clock idle, then a reset in mid-run.
		apb(1'b1, LCFC_CFG_BASE, 32'ha0000);
		cell_in[0] <= '{4'h0, 1'b0, 1'b0, 1'b1, 1'b0};
		repeat (3) @(posedge pclk);
		check(cell_out[0].stored_out, 1'b1);
		check(cell_out[0].table_out, 1'b0);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		check(cell_out[7:0], 24'h0);
		check({cell_out[11:8], carry_out}, 13'h0);
		cell_in[0] <= '0;
		presetn <= 1'b1;
		apb(1'b0, LCFC_CFG_BASE, 32'h0);
		check(rd, 32'h0);
		// Byte strobes: only the two mask bytes are written.
		pstrb <= 4'h3;
		apb(1'b1, LCFC_CFG_BASE, 32'hfffff);
		pstrb <= 4'hf;
		apb(1'b0, LCFC_CFG_BASE, 32'h0);
		check(rd, 32'hffff);
		final_report();
	end
endmodule
